// *** hdl/dsg_clock_gate.sv ***
// Clock gate controller: APB register file, unit enables, fault, interrupt
module dsg_clock_gate (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dsg_pkg::dsg_mode_t powerMode,
  input wire logic unitAccessReq,
  input wire logic [2:0] unitAccessSel,
  output logic unitAccessOk,
  output logic unitBusFault,
  output logic [dsg_pkg::NUM_UNITS-1:0] unitClkEn,
  output logic autoGateSelect,
  output logic irq
);

  typedef struct packed {
    dsg_pkg::dsg_bus_t bus;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [31:0] runGate;
    logic [31:0] sleepGate;
    logic [31:0] deepGate;
    logic [31:0] runCfg;
    logic [2:0] faultUnit;
    logic [dsg_pkg::INT_WIDTH-1:0] intStatus;
    logic [dsg_pkg::INT_WIDTH-1:0] intMask;
    dsg_pkg::dsg_mode_t lastMode;
    logic accessOk;
    logic busFault;
    logic irq;
  } dsg_state_t;

  dsg_state_t state_ff;
  dsg_state_t nxt_state;
  logic [dsg_pkg::NUM_UNITS-1:0] selEn;
  logic [31:0] offset;
  logic hit;
  logic setFault;
  logic setMode;

  // Register decode: 4 KB system control page, word aligned
  function automatic logic isReg(input logic [31:0] a,
                                 input logic [11:0] off);
    isReg = (a[31:20] == dsg_pkg::SYS_CTRL_BASE_HI) &&
            (a[19:12] == 8'hFE) && (a[11:0] == off);
  endfunction : isReg

  // ==========================================================================
  // Gate source selection
  // ==========================================================================
  dsg_gate_select u_select (
    .clk(clk),
    .reset_n(reset_n),
    .powerMode(powerMode),
    .autoGate(state_ff.runCfg[dsg_pkg::BIT_AUTO_GATE]),
    .runGate(state_ff.runGate),
    .sleepGate(state_ff.sleepGate),
    .deepGate(state_ff.deepGate),
    .unitEn(selEn)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_state = state_ff;
    offset = 32'h0000_0000;
    hit = 1'b0;
    setFault = 1'b0;
    setMode = 1'b0;
    nxt_state.ready = 1'b0;
    nxt_state.slverr = 1'b0;
    // Read data only stands in the answer cycle, zero otherwise
    nxt_state.rdata = 32'h0000_0000;
    nxt_state.accessOk = 1'b0;
    nxt_state.busFault = 1'b0;
    nxt_state.lastMode = powerMode;

    // Peripheral access checked against the currently applied enables
    if (unitAccessReq) begin
      if (unitAccessSel < 3'(dsg_pkg::NUM_UNITS) &&
          selEn[unitAccessSel]) begin
        nxt_state.accessOk = 1'b1;
      end else begin
        nxt_state.busFault = 1'b1;
        nxt_state.faultUnit = unitAccessSel;
        setFault = 1'b1;
      end
    end
    if (powerMode != state_ff.lastMode) begin
      setMode = 1'b1;
    end

    unique case (state_ff.bus)
      dsg_pkg::DSG_IDLE: begin
        if (psel && !penable) begin
          nxt_state.bus = dsg_pkg::DSG_ACCESS;
        end
      end
      dsg_pkg::DSG_ACCESS: begin
        // One wait state: answer is registered, then taken on next edge
        if (state_ff.ready) begin
          nxt_state.bus = dsg_pkg::DSG_IDLE;
        end else if (psel && penable) begin
          nxt_state.ready = 1'b1;
          nxt_state.rdata = 32'h0000_0000;
          hit = 1'b1;
          if (isReg(paddr, dsg_pkg::OFF_DEEP_GATE)) begin
            offset = 32'(dsg_pkg::OFF_DEEP_GATE);
            if (pwrite) begin
              // Reserved bits ignore writes
              nxt_state.deepGate = pwdata & dsg_pkg::GATE_WR_MASK;
            end else begin
              nxt_state.rdata = state_ff.deepGate;
            end
          end else if (isReg(paddr, dsg_pkg::OFF_SLEEP_GATE)) begin
            if (pwrite) begin
              nxt_state.sleepGate = pwdata & dsg_pkg::GATE_WR_MASK;
            end else begin
              nxt_state.rdata = state_ff.sleepGate;
            end
          end else if (isReg(paddr, dsg_pkg::OFF_RUN_GATE)) begin
            if (pwrite) begin
              nxt_state.runGate = pwdata & dsg_pkg::GATE_WR_MASK;
            end else begin
              nxt_state.rdata = state_ff.runGate;
            end
          end else if (isReg(paddr, dsg_pkg::OFF_RUN_CFG)) begin
            if (pwrite) begin
              nxt_state.runCfg = pwdata & dsg_pkg::RUN_CFG_WR_MASK;
            end else begin
              nxt_state.rdata = state_ff.runCfg;
            end
          end else if (isReg(paddr, dsg_pkg::OFF_MODE)) begin
            if (!pwrite) begin
              nxt_state.rdata = {30'h0000_0000, powerMode};
            end
          end else if (isReg(paddr, dsg_pkg::OFF_FAULT_LOG)) begin
            if (!pwrite) begin
              nxt_state.rdata = {29'h0000_0000, state_ff.faultUnit};
            end
          end else if (isReg(paddr, dsg_pkg::OFF_INT_STATUS)) begin
            if (!pwrite) begin
              nxt_state.rdata = {30'h0000_0000, state_ff.intStatus};
              // Read clears; events of this same cycle are re-set below
              nxt_state.intStatus = '0;
            end
          end else if (isReg(paddr, dsg_pkg::OFF_INT_MASK)) begin
            if (pwrite) begin
              nxt_state.intMask = pwdata[dsg_pkg::INT_WIDTH-1:0];
            end else begin
              nxt_state.rdata = {30'h0000_0000, state_ff.intMask};
            end
          end else begin
            // Unmapped address answers with an error
            nxt_state.slverr = 1'b1;
          end
        end
      end
      default: nxt_state.bus = dsg_pkg::DSG_IDLE;
    endcase

    // Set wins over the clear-on-read
    if (setFault) begin
      nxt_state.intStatus[dsg_pkg::INT_FAULT] = 1'b1;
    end
    if (setMode) begin
      nxt_state.intStatus[dsg_pkg::INT_MODE_CHG] = 1'b1;
    end
    nxt_state.irq = |(nxt_state.intStatus & nxt_state.intMask);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '0;
      state_ff.runGate <= dsg_pkg::RST_RUN_GATE;
      state_ff.sleepGate <= dsg_pkg::RST_SLEEP_GATE;
      state_ff.deepGate <= dsg_pkg::RST_DEEP_GATE;
      state_ff.runCfg <= dsg_pkg::RST_RUN_CFG;
      state_ff.lastMode <= dsg_pkg::DSG_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata = state_ff.rdata;
  assign pready = state_ff.ready;
  assign pslverr = state_ff.slverr;
  assign unitAccessOk = state_ff.accessOk;
  assign unitBusFault = state_ff.busFault;
  assign unitClkEn = selEn;
  assign autoGateSelect = state_ff.runCfg[dsg_pkg::BIT_AUTO_GATE];
  assign irq = state_ff.irq;

endmodule : dsg_clock_gate

// *** hdl/dsg_gate_select.sv ***
// Gate source selector: picks run, sleep or deep-sleep gate word per mode
module dsg_gate_select (
  input wire logic clk,
  input wire logic reset_n,
  input wire dsg_pkg::dsg_mode_t powerMode,
  input wire logic autoGate,
  input wire logic [31:0] runGate,
  input wire logic [31:0] sleepGate,
  input wire logic [31:0] deepGate,
  output logic [dsg_pkg::NUM_UNITS-1:0] unitEn
);

  typedef struct packed {
    logic [dsg_pkg::NUM_UNITS-1:0] en;
  } dsg_sel_state_t;

  dsg_sel_state_t state_ff;
  dsg_sel_state_t nxt_state;
  logic [31:0] word;

  function automatic logic [dsg_pkg::NUM_UNITS-1:0] unitsOf(
    input logic [31:0] w
  );
    unitsOf = {w[dsg_pkg::BIT_BUS_UNIT_B], w[dsg_pkg::BIT_BUS_UNIT_A],
               w[dsg_pkg::BIT_PWM], w[dsg_pkg::BIT_HIBERNATE],
               w[dsg_pkg::BIT_WATCHDOG]};
  endfunction : unitsOf

  // ==========================================================================
  // Selection
  // ==========================================================================
  always_comb begin
    word = runGate;
    // Without auto gating, low-power modes keep the run settings
    if (autoGate) begin
      unique case (powerMode)
        dsg_pkg::DSG_SLEEP: word = sleepGate;
        dsg_pkg::DSG_DEEP: word = deepGate;
        default: word = runGate;
      endcase
    end
    nxt_state.en = unitsOf(word);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign unitEn = state_ff.en;

endmodule : dsg_gate_select

// *** inc/dsg_pkg.sv ***
// Package: register map, field positions, reset values for the gate block
package dsg_pkg;

  // ==========================================================================
  // Page base bits [31:20] and register offsets (byte addresses)
  // ==========================================================================
  localparam logic [11:0] SYS_CTRL_BASE_HI = 12'h400;
  localparam logic [11:0] OFF_RUN_GATE = 12'h100;
  localparam logic [11:0] OFF_SLEEP_GATE = 12'h110;
  localparam logic [11:0] OFF_DEEP_GATE = 12'h120;
  localparam logic [11:0] OFF_RUN_CFG = 12'h060;
  localparam logic [11:0] OFF_MODE = 12'h200;
  localparam logic [11:0] OFF_FAULT_LOG = 12'h204;
  localparam logic [11:0] OFF_INT_STATUS = 12'h208;
  localparam logic [11:0] OFF_INT_MASK = 12'h20C;

  // ==========================================================================
  // Gate bit positions and the run-config auto-gate bit
  // ==========================================================================
  localparam int BIT_BUS_UNIT_B = 25;
  localparam int BIT_BUS_UNIT_A = 24;
  localparam int BIT_PWM = 20;
  localparam int BIT_HIBERNATE = 6;
  localparam int BIT_WATCHDOG = 3;
  localparam int BIT_AUTO_GATE = 27;

  localparam logic [31:0] GATE_WR_MASK = 32'h0310_0048;
  localparam logic [31:0] RST_DEEP_GATE = 32'h0000_0040;
  localparam logic [31:0] RST_SLEEP_GATE = 32'h0000_0040;
  localparam logic [31:0] RST_RUN_GATE = 32'h0000_0040;
  localparam logic [31:0] RST_RUN_CFG = 32'h0000_0000;
  localparam logic [31:0] RUN_CFG_WR_MASK = 32'h0800_0000;

  // Unit index for the per-unit enable vector
  localparam int NUM_UNITS = 5;
  localparam int UNIT_WATCHDOG = 0;
  localparam int UNIT_HIBERNATE = 1;
  localparam int UNIT_PWM = 2;
  localparam int UNIT_BUS_A = 3;
  localparam int UNIT_BUS_B = 4;

  // Interrupt status bits
  localparam int INT_FAULT = 0;
  localparam int INT_MODE_CHG = 1;
  localparam int INT_WIDTH = 2;

  typedef enum logic [1:0] {
    DSG_RUN = 2'b00,
    DSG_SLEEP = 2'b01,
    DSG_DEEP = 2'b10
  } dsg_mode_t;

  typedef enum logic [1:0] {
    DSG_IDLE = 2'b00,
    DSG_ACCESS = 2'b01
  } dsg_bus_t;

endpackage : dsg_pkg

// *** sim/dsg_clock_gate_asserts.sv ***
// Checker: bus answer and unit access timing of the gate controller
module dsg_clock_gate_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dsg_pkg::dsg_mode_t powerMode,
  input wire logic unitAccessReq,
  input wire logic [2:0] unitAccessSel,
  input wire logic unitAccessOk,
  input wire logic unitBusFault,
  input wire logic [dsg_pkg::NUM_UNITS-1:0] unitClkEn,
  input wire logic autoGateSelect,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_known; unitAccessReq && unitAccessSel < 3'h5; endsequence
  a_bus_answer: assert property (
    s_setup ##1 s_access |=> pready) else $error("no answer");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("ready too long");
  a_ready_cause: assert property (
    pready |-> $past(psel && penable)) else $error("stray ready");
  a_rdata_idle: assert property (
    !pready |-> prdata == 32'h0) else $error("read data leak");
  a_gated_fault: assert property (
    s_known ##0 !unitClkEn[unitAccessSel] |=> unitBusFault && !unitAccessOk)
    else $error("gated unit not faulted");
  a_clocked_ok: assert property (
    s_known ##0 unitClkEn[unitAccessSel] |=> unitAccessOk && !unitBusFault)
    else $error("clocked unit refused");
  a_bad_sel: assert property (
    unitAccessReq && unitAccessSel > 3'h4 |=> unitBusFault)
    else $error("bad unit not faulted");
  a_quiet_idle: assert property (
    !unitAccessReq |=> !unitAccessOk && !unitBusFault)
    else $error("answer without request");
endmodule : dsg_clock_gate_asserts

bind dsg_clock_gate dsg_clock_gate_asserts dsg_clock_gate_asserts_inst (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .powerMode(powerMode),
  .unitAccessReq(unitAccessReq), .unitAccessSel(unitAccessSel),
  .unitAccessOk(unitAccessOk), .unitBusFault(unitBusFault),
  .unitClkEn(unitClkEn), .autoGateSelect(autoGateSelect), .irq(irq));

// *** sim/dsg_clock_gate_tb.sv ***
// Testbench: register access, mode selection and unit faults of the gate
module dsg_clock_gate_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, unitAccessReq = 0, unitAccessOk, unitBusFault;
  logic [2:0] unitAccessSel = 3'h0;
  logic [4:0] unitClkEn;
  logic autoGateSelect, irq;
  dsg_pkg::dsg_mode_t powerMode = dsg_pkg::DSG_RUN;
  int numErrors = 0, samplesChecked = 0;
  localparam logic [31:0] BASE = 32'h400F_E000;
  int bitPos [5] = '{3, 6, 20, 24, 25};
  dsg_clock_gate dsg_clock_gate_inst (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerMode(powerMode), .unitAccessReq(unitAccessReq),
    .unitAccessSel(unitAccessSel), .unitAccessOk(unitAccessOk),
    .unitBusFault(unitBusFault), .unitClkEn(unitClkEn),
    .autoGateSelect(autoGateSelect), .irq(irq));
  initial begin
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task completeRun;
    if (numErrors == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : completeRun
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] off, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= BASE + {20'h0, off};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      numErrors++;
      completeRun();
    end
  endtask : apb
  task cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  // Answer for a unit comes one cycle after the request is taken
  task access(input logic [2:0] s, input logic expOk);
    @(posedge clk);
    unitAccessReq <= 1'b1;
    unitAccessSel <= s;
    @(posedge clk);
    unitAccessReq <= 1'b0;
    @(posedge clk);
    chk("unit answer", {30'h0, expOk, !expOk}, {30'h0, unitAccessOk,
      unitBusFault});
  endtask : access
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    cycles(20);
    reset_n <= 1'b1;
    cycles(2);
    chk("enables", 32'h2, {27'h0, unitClkEn});
    apb(0, 12'h120, 0);
    chk("deep reset", 32'h0000_0040, rd);
    apb(1, 12'h20C, 32'h1);
    apb(1, 12'h120, 32'hFFFF_FFFF);
    apb(0, 12'h120, 0);
    chk("deep rw", 32'h0310_0048, rd);
    powerMode <= dsg_pkg::DSG_DEEP;
    cycles(3);
    chk("no auto", 32'h2, {27'h0, unitClkEn});
    apb(1, 12'h060, 32'h0800_0000);
    cycles(2);
    chk("auto bit", 32'h1, {31'h0, autoGateSelect});
    chk("deep en", 32'h1F, {27'h0, unitClkEn});
    powerMode <= dsg_pkg::DSG_SLEEP;
    cycles(3);
    chk("sleep en", 32'h2, {27'h0, unitClkEn});
    powerMode <= dsg_pkg::DSG_RUN;
    apb(1, 12'h120, 32'h0);
    cycles(2);
    chk("run en", 32'h2, {27'h0, unitClkEn});
    powerMode <= dsg_pkg::DSG_DEEP;
    for (int i = 0; i < 5; i++) begin
      apb(1, 12'h120, 32'h1 << bitPos[i]);
      cycles(2);
      chk("unit bit", 32'h1 << i, {27'h0, unitClkEn});
    end
    for (int s = 0; s < 6; s++) begin
      access(s[2:0], s == 4);
    end
    cycles(3);
    chk("irq set", 32'h1, {31'h0, irq});
    apb(0, 12'h208, 0);
    chk("status", 32'h1, {31'h0, rd[0]});
    cycles(3);
    chk("irq clear", 32'h0, {31'h0, irq});
    apb(0, 12'h3F0, 0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped rd", 32'h0, rd);
    completeRun();
  end
endmodule : dsg_clock_gate_tb
